// [hw/gpio_pkg.sv]
// Contract
// [R1] Six-pin function one routes pins 5,3,2,1,0 to interrupt/serial signals.
// [R2] Six-pin function three routes pins 4..1 to timer capture inputs.
// [R3] Six-pin function four bit 5 routes pin 5 to bus-power detect.
// [R4] Unassigned control register bits read back as zero.
// [R5] Drain-mode bit 0 gives push-pull, 1 gives open-drain, six-pin port.
// [R6] Pull-up bit enables the six-pin pin's pull-up resistor.
// [R7] Input enable bit opens the six-pin pin input buffer, else blocked.
// [R8] Five-pin port pins are each independently input or output.
// [R9] Reset leaves five-pin port as plain I/O, all drivers off.
// [R10] Software sets at most one function bit per pin.
// [R11] Outside stop mode, input enable alone passes pin to interrupt.
// [R12] Software should disable unused interrupt sources.
// [R13] Five-pin port registers decode at their printed offsets.
// [R14] Masters avoid reserved offsets in the register window.
// [R15] Five-pin data register bits 4..0 map pins 4..0, reset zero.
// [R16] Reset leaves six-pin port as plain I/O, all drivers off.
// [R17] Six-pin port registers decode at their printed offsets.
// [R18] Output control bit enables six-pin output driver.
// [R19] Writes to read-only zero bits are ignored.
package gpio_pkg;
  localparam int unsigned G_WIDTH = 6;
  localparam int unsigned H_WIDTH = 5;
  localparam logic [31:0] G_BASE = 32'h400c_0600;
  localparam logic [31:0] H_BASE = 32'h400c_0700;
  localparam logic [31:0] WIN_MASK = 32'hffff_ff00;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_OUT_EN = 8'h04;
  localparam logic [7:0] OFS_FUNC1 = 8'h08;
  localparam logic [7:0] OFS_FUNC3 = 8'h10;
  localparam logic [7:0] OFS_FUNC4 = 8'h14;
  localparam logic [7:0] OFS_DRAIN = 8'h28;
  localparam logic [7:0] OFS_PULLUP = 8'h2c;
  localparam logic [7:0] OFS_IN_EN = 8'h38;
  // Writable masks; everything else reads zero
  localparam logic [5:0] G_ALL_MASK = 6'h3f;
  localparam logic [5:0] G_FUNC1_MASK = 6'h2f;
  localparam logic [5:0] G_FUNC3_MASK = 6'h1e;
  localparam logic [5:0] G_FUNC4_MASK = 6'h20;
  localparam logic [4:0] H_ALL_MASK = 5'h1f;
  localparam logic [4:0] H_FUNC1_MASK = 5'h03;
  localparam logic [4:0] H_FUNC3_MASK = 5'h1c;
  localparam logic [5:0] G_RESET = 6'h00;
  localparam logic [4:0] H_RESET = 5'h00;
  // Six-pin function routing positions
  localparam int unsigned G_PIN_EXTERNAL_INTERRUPT_ONE = 5;
  localparam int unsigned G_PIN_INT0 = 3;
  localparam int unsigned G_PIN_SCK = 2;
  localparam int unsigned G_PIN_SCL = 1;
  localparam int unsigned G_PIN_SDA = 0;
  localparam int unsigned G_PIN_TBB1 = 4;
  localparam int unsigned G_PIN_TBB0 = 3;
  localparam int unsigned G_PIN_TBA1 = 2;
  localparam int unsigned G_PIN_TBA0 = 1;
  localparam int unsigned G_PIN_VBUS = 5;

  // Pad control for one port
  typedef struct packed {
    logic [5:0] drive_en;
    logic [5:0] open_drain;
    logic [5:0] pullup_en;
    logic [5:0] input_en;
  } g_pad_t;

  typedef struct packed {
    logic [4:0] drive_en;
    logic [4:0] open_drain;
    logic [4:0] pullup_en;
    logic [4:0] input_en;
  } h_pad_t;

  // Signals routed from six-pin port to peripherals
  typedef struct packed {
    logic ext_int_one;
    logic ext_int_zero;
    logic serial_clock_line;
    logic i2c_clock_or_serial_in;
    logic i2c_data_or_serial_out;
    logic timer_b_capture_in_one;
    logic timer_b_capture_in_zero;
    logic timer_a_capture_in_one;
    logic timer_a_capture_in_zero;
    logic bus_power_detect;
  } g_periph_t;
endpackage

// [hw/pin_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of pin levels
module pin_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// [hw/dual_gpio_port.sv]
`timescale 1ns/1ps
// Control logic for the six-pin and five-pin ports behind an APB slave
module dual_gpio_port (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 stop_mode,
  input  wire logic [5:0]           g_pin_in,
  output logic      [5:0]           g_pin_out,
  output logic      [5:0]           g_pin_oe,
  output gpio_pkg::g_pad_t          g_pad,
  input  wire logic [4:0]           h_pin_in,
  output logic      [4:0]           h_pin_out,
  output logic      [4:0]           h_pin_oe,
  output gpio_pkg::h_pad_t          h_pad,
  output gpio_pkg::g_periph_t       g_periph,
  output logic      [4:0]           h_ext_int
);
  // Six-pin port control registers
  logic [5:0] g_data_r;
  logic [5:0] g_oe_r;
  logic [5:0] g_f1_r;
  logic [5:0] g_f3_r;
  logic [5:0] g_f4_r;
  logic [5:0] g_od_r;
  logic [5:0] g_pu_r;
  logic [5:0] g_ie_r;
  // Five-pin port control registers
  logic [4:0] h_data_r;
  logic [4:0] h_oe_r;
  logic [4:0] h_f1_r;
  logic [4:0] h_f3_r;
  logic [4:0] h_od_r;
  logic [4:0] h_pu_r;
  logic [4:0] h_ie_r;
  logic [5:0] g_sync;
  logic [4:0] h_sync;
  logic       stop_s1_r;
  logic       stop_r;
  logic       sel_g;
  logic       sel_h;
  logic [7:0] ofs;
  logic       g_hit;
  logic       h_hit;
  logic       wr_en;
  logic       rd_en;
  logic [31:0] rd_nxt;
  logic [5:0] g_in_gated;
  logic [4:0] h_in_gated;
  logic [5:0] g_inten;
  logic [4:0] h_inten;

  // Is this offset one of the six-pin port's registers
  function automatic logic g_valid(input logic [7:0] o);
    g_valid = (o == gpio_pkg::OFS_DATA) || (o == gpio_pkg::OFS_OUT_EN)
           || (o == gpio_pkg::OFS_FUNC1) || (o == gpio_pkg::OFS_FUNC3)
           || (o == gpio_pkg::OFS_FUNC4) || (o == gpio_pkg::OFS_DRAIN)
           || (o == gpio_pkg::OFS_PULLUP) || (o == gpio_pkg::OFS_IN_EN);
  endfunction

  // Five-pin port lacks function four
  function automatic logic h_valid(input logic [7:0] o);
    h_valid = g_valid(o) && (o != gpio_pkg::OFS_FUNC4);
  endfunction

  // Pin sync: pins are outside the clock domain
  pin_sync #(.WIDTH(gpio_pkg::G_WIDTH)) u_g_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (g_pin_in),
    .sync_out (g_sync)
  );

  pin_sync #(.WIDTH(gpio_pkg::H_WIDTH)) u_h_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (h_pin_in),
    .sync_out (h_sync)
  );

  // Stop mode comes from the power controller, assumed unrelated timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_s1_r <= 1'b0;
      stop_r    <= 1'b0;
    end else begin
      stop_s1_r <= stop_mode;
      stop_r    <= stop_s1_r;
    end
  end

  // Address decode
  assign sel_g = (paddr & gpio_pkg::WIN_MASK) == gpio_pkg::G_BASE;
  assign sel_h = (paddr & gpio_pkg::WIN_MASK) == gpio_pkg::H_BASE;
  assign ofs   = paddr[7:0];
  assign g_hit = sel_g && g_valid(ofs); // [R17]
  assign h_hit = sel_h && h_valid(ofs); // [R13]
  // Zero-wait slave: writes land on the access edge
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Six-pin register writes, masked so read-only bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g_data_r <= gpio_pkg::G_RESET;
      g_oe_r   <= gpio_pkg::G_RESET; // [R16]
      g_f1_r   <= gpio_pkg::G_RESET;
      g_f3_r   <= gpio_pkg::G_RESET;
      g_f4_r   <= gpio_pkg::G_RESET;
      g_od_r   <= gpio_pkg::G_RESET;
      g_pu_r   <= gpio_pkg::G_RESET;
      g_ie_r   <= gpio_pkg::G_RESET;
    end else if (wr_en && g_hit) begin
      unique case (ofs)
        gpio_pkg::OFS_DATA:
          g_data_r <= pwdata[5:0] & gpio_pkg::G_ALL_MASK;
        gpio_pkg::OFS_OUT_EN:
          g_oe_r <= pwdata[5:0] & gpio_pkg::G_ALL_MASK;
        gpio_pkg::OFS_FUNC1:
          g_f1_r <= pwdata[5:0] & gpio_pkg::G_FUNC1_MASK; // [R19]
        gpio_pkg::OFS_FUNC3:
          g_f3_r <= pwdata[5:0] & gpio_pkg::G_FUNC3_MASK; // [R19]
        gpio_pkg::OFS_FUNC4:
          g_f4_r <= pwdata[5:0] & gpio_pkg::G_FUNC4_MASK; // [R19]
        gpio_pkg::OFS_DRAIN:
          g_od_r <= pwdata[5:0] & gpio_pkg::G_ALL_MASK;
        gpio_pkg::OFS_PULLUP:
          g_pu_r <= pwdata[5:0] & gpio_pkg::G_ALL_MASK;
        gpio_pkg::OFS_IN_EN:
          g_ie_r <= pwdata[5:0] & gpio_pkg::G_ALL_MASK;
        default: ;
      endcase
    end
  end

  // Five-pin register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_data_r <= gpio_pkg::H_RESET; // [R15]
      h_oe_r   <= gpio_pkg::H_RESET; // [R9]
      h_f1_r   <= gpio_pkg::H_RESET;
      h_f3_r   <= gpio_pkg::H_RESET;
      h_od_r   <= gpio_pkg::H_RESET;
      h_pu_r   <= gpio_pkg::H_RESET;
      h_ie_r   <= gpio_pkg::H_RESET;
    end else if (wr_en && h_hit) begin
      unique case (ofs)
        gpio_pkg::OFS_DATA:
          h_data_r <= pwdata[4:0] & gpio_pkg::H_ALL_MASK; // [R15]
        gpio_pkg::OFS_OUT_EN:
          h_oe_r <= pwdata[4:0] & gpio_pkg::H_ALL_MASK; // [R8]
        gpio_pkg::OFS_FUNC1:
          h_f1_r <= pwdata[4:0] & gpio_pkg::H_FUNC1_MASK; // [R19]
        gpio_pkg::OFS_FUNC3:
          h_f3_r <= pwdata[4:0] & gpio_pkg::H_FUNC3_MASK; // [R19]
        gpio_pkg::OFS_DRAIN:
          h_od_r <= pwdata[4:0] & gpio_pkg::H_ALL_MASK;
        gpio_pkg::OFS_PULLUP:
          h_pu_r <= pwdata[4:0] & gpio_pkg::H_ALL_MASK;
        gpio_pkg::OFS_IN_EN:
          h_ie_r <= pwdata[4:0] & gpio_pkg::H_ALL_MASK;
        default: ;
      endcase
    end
  end

  // Pins read through the input buffer only when enabled
  assign g_in_gated = g_sync & g_ie_r; // [R7]
  assign h_in_gated = h_sync & h_ie_r;

  // Read mux: data register shows pin level for inputs, latch for outputs
  always_comb begin
    rd_nxt = 32'h0000_0000; // [R4]
    if (g_hit) begin
      unique case (ofs)
        gpio_pkg::OFS_DATA:
          rd_nxt[5:0] = (g_data_r & g_oe_r) | (g_in_gated & ~g_oe_r);
        gpio_pkg::OFS_OUT_EN: rd_nxt[5:0] = g_oe_r;
        gpio_pkg::OFS_FUNC1:  rd_nxt[5:0] = g_f1_r;
        gpio_pkg::OFS_FUNC3:  rd_nxt[5:0] = g_f3_r;
        gpio_pkg::OFS_FUNC4:  rd_nxt[5:0] = g_f4_r;
        gpio_pkg::OFS_DRAIN:  rd_nxt[5:0] = g_od_r;
        gpio_pkg::OFS_PULLUP: rd_nxt[5:0] = g_pu_r;
        gpio_pkg::OFS_IN_EN:  rd_nxt[5:0] = g_ie_r;
        default: ;
      endcase
    end else if (h_hit) begin
      unique case (ofs)
        gpio_pkg::OFS_DATA:
          rd_nxt[4:0] = (h_data_r & h_oe_r) | (h_in_gated & ~h_oe_r);
        gpio_pkg::OFS_OUT_EN: rd_nxt[4:0] = h_oe_r;
        gpio_pkg::OFS_FUNC1:  rd_nxt[4:0] = h_f1_r;
        gpio_pkg::OFS_FUNC3:  rd_nxt[4:0] = h_f3_r;
        gpio_pkg::OFS_DRAIN:  rd_nxt[4:0] = h_od_r;
        gpio_pkg::OFS_PULLUP: rd_nxt[4:0] = h_pu_r;
        gpio_pkg::OFS_IN_EN:  rd_nxt[4:0] = h_ie_r;
        default: ;
      endcase
    end
  end

  // Bus answer registered in setup, valid in access; always ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (rd_en) begin
        prdata <= rd_nxt;
      end
      // Unmapped or reserved offset flags an error, no state changes
      if (psel && !penable) begin
        pslverr <= !(g_hit || h_hit);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Interrupt paths follow input enable, not function select
  assign g_inten = stop_r ? 6'h00 : g_in_gated; // [R11]
  assign h_inten = stop_r ? 5'h00 : h_in_gated; // [R11]

  // Pad drives: open-drain only pulls low, push-pull drives both ways
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g_pin_out <= '0;
      g_pin_oe  <= '0;
      h_pin_out <= '0;
      h_pin_oe  <= '0;
      g_pad     <= '0;
      h_pad     <= '0;
    end else begin
      g_pin_out <= g_data_r;
      g_pin_oe  <= g_oe_r & ~(g_od_r & g_data_r); // [R5] [R18]
      h_pin_out <= h_data_r;
      h_pin_oe  <= h_oe_r & ~(h_od_r & h_data_r); // [R8]
      g_pad.drive_en   <= g_oe_r; // [R18]
      g_pad.open_drain <= g_od_r; // [R5]
      g_pad.pullup_en  <= g_pu_r; // [R6]
      g_pad.input_en   <= g_ie_r; // [R7]
      h_pad.drive_en   <= h_oe_r;
      h_pad.open_drain <= h_od_r;
      h_pad.pullup_en  <= h_pu_r;
      h_pad.input_en   <= h_ie_r;
    end
  end

  // Peripheral routing; a function bit of 0 leaves the serial, timer and bus-power inputs idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g_periph  <= '0;
      h_ext_int <= '0;
    end else begin
      g_periph.ext_int_one  <= g_inten[gpio_pkg::G_PIN_EXTERNAL_INTERRUPT_ONE]; // [R1] [R11]
      g_periph.ext_int_zero <= g_inten[gpio_pkg::G_PIN_INT0]; // [R1] [R11]
      g_periph.serial_clock_line <=
        g_f1_r[gpio_pkg::G_PIN_SCK] & g_in_gated[gpio_pkg::G_PIN_SCK]; // [R1]
      g_periph.i2c_clock_or_serial_in <=
        g_f1_r[gpio_pkg::G_PIN_SCL] & g_in_gated[gpio_pkg::G_PIN_SCL]; // [R1]
      g_periph.i2c_data_or_serial_out <=
        g_f1_r[gpio_pkg::G_PIN_SDA] & g_in_gated[gpio_pkg::G_PIN_SDA]; // [R1]
      g_periph.timer_b_capture_in_one <=
        g_f3_r[gpio_pkg::G_PIN_TBB1] & g_in_gated[gpio_pkg::G_PIN_TBB1]; // [R2]
      g_periph.timer_b_capture_in_zero <=
        g_f3_r[gpio_pkg::G_PIN_TBB0] & g_in_gated[gpio_pkg::G_PIN_TBB0]; // [R2]
      g_periph.timer_a_capture_in_one <=
        g_f3_r[gpio_pkg::G_PIN_TBA1] & g_in_gated[gpio_pkg::G_PIN_TBA1]; // [R2]
      g_periph.timer_a_capture_in_zero <=
        g_f3_r[gpio_pkg::G_PIN_TBA0] & g_in_gated[gpio_pkg::G_PIN_TBA0]; // [R2]
      g_periph.bus_power_detect <=
        g_f4_r[gpio_pkg::G_PIN_VBUS] & g_in_gated[gpio_pkg::G_PIN_VBUS]; // [R3]
      h_ext_int <= h_inten;
    end
  end
endmodule

// [tb/pin_model.sv]
`timescale 1ns/1ps
// Far side of one port: pads, pull-ups and an outside driver
module pin_model #(
  parameter int W = 6
) (
  input  wire logic         pclk,
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] pullup_en,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin_in
);
  logic [W-1:0] float_r = '0;
  // A floating pad wanders, so a stale level never reads as valid
  always @(posedge pclk) float_r <= ~float_r;
  // Our driver wins; an open-drain high releases the pad
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & pullup_en)
    | (~pin_oe & ~ext_en & ~pullup_en & float_r);
endmodule

// [tb/dual_gpio_port_asserts.sv]
`timescale 1ns/1ps
// Port-level relations of the dual port block
module dual_gpio_port_asserts (
  input wire logic      pclk,
  input wire logic      presetn,
  input wire logic      psel,
  input wire logic      penable,
  input wire logic      pwrite,
  input wire logic [31:0] prdata,
  input wire logic      pready,
  input wire logic      pslverr,
  input wire logic      stop_mode,
  input wire logic [5:0] g_pin_out,
  input wire logic [5:0] g_pin_oe,
  input gpio_pkg::g_pad_t g_pad,
  input wire logic [4:0] h_pin_out,
  input wire logic [4:0] h_pin_oe,
  input gpio_pkg::h_pad_t h_pad,
  input gpio_pkg::g_periph_t g_periph,
  input wire logic [4:0] h_ext_int
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  zero_wait_a: assert property (setup_s |=> access_s)
    else $error("no answer after setup");
  ready_cause_a: assert property (
    pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  read_upper_a: assert property (
    pready && !pwrite |-> prdata[31:6] == 26'h0)
    else $error("upper read bits set");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error outside access");
  reset_pads_a: assert property ($rose(presetn)
    |-> g_pad == 24'h0
    && h_pad == 20'h0 && g_pin_oe == 6'h0 && h_pin_oe == 5'h0)
    else $error("pads not idle after reset");
  g_drive_a: assert property (
    $stable(g_pad) && $stable(g_pin_out)
    |-> g_pin_oe == (g_pad.drive_en & ~(g_pad.open_drain & g_pin_out)))
    else $error("six-pin enable wrong");
  h_drive_a: assert property ($stable(h_pad) && $stable(h_pin_out)
    |-> h_pin_oe == (h_pad.drive_en & ~(h_pad.open_drain & h_pin_out)))
    else $error("five-pin enable wrong");
  stop_block_a: assert property (stop_mode [*4]
    |-> h_ext_int == 5'h0
    && !g_periph.ext_int_one && !g_periph.ext_int_zero)
    else $error("interrupt in stop");
  in_block_a: assert property ((h_pad.input_en == 5'h0) [*4]
    |-> h_ext_int == 5'h0)
    else $error("interrupt with input off");
  vbus_gate_a: assert property ((!g_pad.input_en[5]) [*4]
    |-> !g_periph.bus_power_detect)
    else $error("detect with input off");
endmodule

bind dual_gpio_port dual_gpio_port_asserts u_dual_gpio_port_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .stop_mode, .g_pin_out, .g_pin_oe, .g_pad, .h_pin_out, .h_pin_oe,
  .h_pad, .g_periph, .h_ext_int);

// [tb/dual_gpio_port_test.sv]
`timescale 1ns/1ps
// Self-checking bench for the dual port block
module dual_gpio_port_test;
  localparam logic [31:0] GB = gpio_pkg::G_BASE;
  localparam logic [31:0] HB = gpio_pkg::H_BASE;
  logic        pclk, pready, pslverr;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, stop_mode = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, d;
  logic [5:0]  g_in, g_out, g_oe, gi, f1, f3, f4, e;
  logic [5:0]  g_ev = 6'h0, g_ee = 6'h0;
  logic [4:0]  h_in, h_out, h_oe, h_int, hi, ho;
  logic [4:0]  h_ev = 5'h0, h_ee = 5'h0;
  logic [32:0] q[$];
  logic [32:0] nt;
  gpio_pkg::g_pad_t    g_pad;
  gpio_pkg::h_pad_t    h_pad;
  gpio_pkg::g_periph_t g_per;
  int          n_fail = 0, checked = 0, seed = 32'hb136aeeb, i, k;
  logic [7:0]  ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h28, 8'h2c,
                          8'h38};
  logic [5:0]  gm[8] = '{6'h3f, 6'h3f, 6'h2f, 6'h1e, 6'h20, 6'h3f, 6'h3f, 6'h3f};
  logic [4:0]  hm[8] = '{5'h1f, 5'h1f, 5'h03, 5'h1c, 5'h00, 5'h1f, 5'h1f, 5'h1f};

  dual_gpio_port u_dual_gpio_port (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .stop_mode, .g_pin_in(g_in), .g_pin_out(g_out),
    .g_pin_oe(g_oe), .g_pad, .h_pin_in(h_in), .h_pin_out(h_out),
    .h_pin_oe(h_oe), .h_pad, .g_periph(g_per), .h_ext_int(h_int));
  pin_model #(.W(6)) u_pin_model_g (.pclk, .pin_out(g_out), .pin_oe(g_oe),
    .pullup_en(g_pad.pullup_en), .ext_val(g_ev), .ext_en(g_ee),
    .pin_in(g_in));
  pin_model #(.W(5)) u_pin_model_h (.pclk, .pin_out(h_out), .pin_oe(h_oe),
    .pullup_en(h_pad.pullup_en), .ext_val(h_ev), .ext_en(h_ee),
    .pin_in(h_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  // Starts just after a rising edge; leaves the request up at the end
  task xfer(input logic w, input logic [31:0] a, d, input logic [32:0] x);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Ready is sampled at the rising edge that ends the access phase
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h1, 32'h0, "no ready");
      complete_run();
    end
  endtask

  task wr(input logic [31:0] a, d);
    xfer(1'b1, a, d, 33'h0);
  endtask

  task rd(input logic [31:0] a, input logic [32:0] x);
    xfer(1'b0, a, 32'h0, x);
  endtask

  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Pads lag a write by one cycle, pin inputs by three
  task settle;
    idle();
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Scoreboard: the oldest note meets each answered transfer
  always @(negedge pclk) begin
    if (psel && penable && pready && q.size() > 0) begin
      nt = q.pop_front();
      chk(pslverr, nt[32], "error flag");
      if (!pwrite) chk(prdata, nt[31:0], "read data");
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 8; i++) begin
      rd(GB + ofs[i], 33'h0);
      rd(HB + ofs[i], {i == 4, 32'h0});
    end
    $display("done reset");
    for (k = 0; k < 3; k++) begin
      for (i = 1; i < 8; i++) begin
        d = (k == 0) ? 32'hffffffff : $random(seed);
        wr(GB + ofs[i], d);
        rd(GB + ofs[i], {27'h0, gm[i] & d[5:0]});
        xfer(1'b1, HB + ofs[i], d, {i == 4, 32'h0});
        rd(HB + ofs[i], {i == 4, 27'h0, hm[i] & d[4:0]});
        // Only one function register may hold ones at a time
        if (i >= 2 && i <= 4) begin
          wr(GB + ofs[i], 32'h0);
          xfer(1'b1, HB + ofs[i], 32'h0, {i == 4, 32'h0});
        end
      end
    end
    rd(GB + 32'hc, {1'b1, 32'h0});
    rd(32'h400c_0800, {1'b1, 32'h0});
    $display("done registers");
    d = $random(seed);
    wr(GB + 32'h38, 32'h0);
    wr(GB + 32'h4, 32'h3f);
    wr(GB, d);
    wr(GB + 32'h28, 32'h0);
    settle();
    chk(g_out, d[5:0], "drive level");
    chk(g_oe, 6'h3f, "push-pull enable");
    @(posedge pclk);
    wr(GB + 32'h28, 32'h3f);
    settle();
    chk(g_oe, 6'h3f & ~d[5:0], "open-drain enable");
    @(posedge pclk);
    rd(GB, {27'h0, d[5:0]});
    wr(GB + 32'h4, 32'h0);
    wr(GB + 32'h2c, 32'h3f);
    wr(GB + 32'h38, 32'h3f);
    settle();
    @(posedge pclk);
    rd(GB, {27'h0, 6'h3f});
    wr(GB + 32'h38, 32'h0);
    settle();
    @(posedge pclk);
    rd(GB, 33'h0);
    $display("done pads");
    d = $random(seed);
    ho = d[9:5];
    h_ev <= d[14:10];
    h_ee <= ~d[9:5];
    wr(HB + 32'h28, 32'h0);
    wr(HB + 32'h4, {27'h0, ho});
    wr(HB, d);
    wr(HB + 32'h38, 32'h1f);
    settle();
    chk(h_oe, ho, "five-pin enable");
    @(posedge pclk);
    rd(HB, {28'h0, (ho & d[4:0]) | (~ho & h_ev)});
    wr(HB + 32'h4, 32'h0);
    $display("done five-pin");
    for (k = 0; k < 6; k++) begin
      d = $random(seed);
      f1 = k[0] ? 6'h00 : 6'h2f;
      f3 = ~f1 & 6'h1e;
      f4 = ~f1 & 6'h20;
      gi = d[11:6];
      hi = d[21:17];
      g_ev <= d[5:0];
      g_ee <= 6'h3f;
      h_ev <= d[16:12];
      h_ee <= 5'h1f;
      stop_mode <= (k > 3);
      // Clear function one first so no pin ever has two functions
      wr(GB + 32'h8, 32'h0);
      wr(GB + 32'h10, {26'h0, f3});
      wr(GB + 32'h14, {26'h0, f4});
      wr(GB + 32'h8, {26'h0, f1});
      wr(GB + 32'h38, {26'h0, gi});
      wr(HB + 32'h38, {27'h0, hi});
      settle();
      e = g_ev & gi;
      chk(g_per, {e[5] & ~stop_mode, e[3] & ~stop_mode, e[2:0] & f1[2:0],
        e[4:1] & f3[4:1], e[5] & f4[5]}, "routing");
      chk(h_int, h_ev & hi & {5{~stop_mode}}, "five-pin int");
      @(posedge pclk);
    end
    stop_mode <= 1'b0;
    wr(GB + 32'h38, 32'h0);
    wr(HB + 32'h38, 32'h0);
    idle();
    $display("done routing");
    complete_run();
  end
endmodule
